// [design/clock_fanout_pkg.sv]
// constants shared by the clock fan-out design
// assumes one 125 MHz system clock that samples the reference and feedback pins
package clock_fanout_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned BANK_A_N = 5;
   localparam int unsigned BANK_B_N = 4;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned STAB_W = 17;
   localparam int unsigned SYNC_W = 5;
   // lock time limit, in microseconds as specified
   localparam int unsigned STAB_TIME_US = 1000;
   // longest time in system clock cycles
   localparam int unsigned STAB_CYCLES_DEF = STAB_TIME_US * CLK_MHZ;
   localparam logic [CNT_W-1:0] LOCK_REF_CYCLES = 16'h0040;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [STAB_W-1:0] STAB_ZERO = 17'h00000;
   localparam logic [STAB_W-1:0] STAB_MAX = 17'h1FFFF;
   // bit positions in the synchroniser bundle
   localparam int unsigned SY_REF = 0;
   localparam int unsigned SY_FB = 1;
   localparam int unsigned SY_EN_A = 2;
   localparam int unsigned SY_EN_B = 3;
   localparam int unsigned SY_STRAP = 4;
endpackage : clock_fanout_pkg

// [design/pin_sync.sv]
// two-stage synchroniser for a bundle of asynchronous pins
// assumes pins are static or slow compared with clock_in
module pin_sync
   import clock_fanout_pkg::*;
#(
   parameter int unsigned W = SYNC_W
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [W-1:0] pins_in,
   output logic [W-1:0] synced_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   always_comb begin
      next_st = st;
      if (ce_in) begin
         next_st.s1 = pins_in;
         next_st.s2 = st.s1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign synced_out = st.s2;
endmodule : pin_sync

// [design/clock_fanout.sv]
// digital model of a phase-locked clock fan-out driver with two gated banks
// assumes the reference is slow enough to be sampled at 125 MHz (at least 4 cycles a period)
// assumes feedback_out is wired back to feedback_in on the board
// assumes rst_in is raised once before use; the device itself has no reset
// outside bypass, outputs come from an internal generator, which a sampled glitch on the reference pin restarts early
//
// Notes on behaviour
// - Nine copies of the reference are driven, five in bank a and four in bank b.
// - Outside bypass, each output is regenerated with a 50 percent duty cycle whatever the input duty.
// - Bank a outputs sit low while bank_a_enable is low and toggle when it is high.
// - Bank b outputs sit low while bank_b_enable is low and toggle when it is high.
// - Enabled outputs follow the reference in phase and frequency.
// - feedback_out is a dedicated copy at the reference frequency for loop feedback.
// - The loop shifts its phase until feedback_in rises together with the reference.
// - After start-up, a stopped reference, or a reference period or feedback phase off by over one clock, lock is lost and rebuilt.
// - Lock is reached within 1 ms; before lock no timing promise holds.
// - With analog_supply_strap low the loop is bypassed and the reference is buffered out.
module clock_fanout
   import clock_fanout_pkg::*;
#(
   parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic ref_clock_in,
   input wire logic feedback_in,
   input wire logic bank_a_enable,
   input wire logic bank_b_enable,
   input wire logic analog_supply_strap,
   output logic [BANK_A_N-1:0] bank_a_outputs,
   output logic [BANK_B_N-1:0] bank_b_outputs,
   output logic feedback_out,
   output logic lock_out
);
   typedef struct packed {
      logic ref_d;
      logic fb_d;
      logic [CNT_W-1:0] ref_cnt;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] gen_cnt;
      logic [CNT_W-1:0] adv;
      logic [CNT_W-1:0] fb_cnt;
      logic [CNT_W-1:0] stable;
      logic [STAB_W-1:0] stab_timer;
      logic locked;
      logic a_on;
      logic b_on;
      logic src_d;
      logic [BANK_A_N-1:0] bank_a;
      logic [BANK_B_N-1:0] bank_b;
      logic fb_o;
   } fanout_state_t;

   fanout_state_t st;
   fanout_state_t next_st;
   logic [SYNC_W-1:0] synced;

   // every pin, the strap too, crosses two flops before any logic reads it
   pin_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pins_in({analog_supply_strap, bank_b_enable, bank_a_enable, feedback_in, ref_clock_in}),
      .synced_out(synced)
   );

   logic ref_s;
   logic fb_s;
   logic bypass;

   assign ref_s = synced[SY_REF];
   assign fb_s = synced[SY_FB];
   // strap tied low means the loop is skipped
   assign bypass = ~synced[SY_STRAP];

   always_comb begin
      logic ref_rise;
      logic fb_rise;
      logic disturb;
      logic src;
      logic [CNT_W-1:0] new_period;
      logic [CNT_W-1:0] diff;
      logic [CNT_W-1:0] gen_nx;

      ref_rise = 1'b0;
      fb_rise = 1'b0;
      disturb = 1'b0;
      src = 1'b0;
      new_period = CNT_ZERO;
      diff = CNT_ZERO;
      gen_nx = CNT_ZERO;

      next_st = st;
      if (ce_in) begin
         ref_rise = ref_s & ~st.ref_d;
         fb_rise = fb_s & ~st.fb_d;
         next_st.ref_d = ref_s;
         next_st.fb_d = fb_s;

         if (st.ref_cnt != CNT_MAX) begin
            next_st.ref_cnt = st.ref_cnt + CNT_ONE;
         end
         // a saturated count means the reference has stopped
         if (st.ref_cnt == CNT_MAX) begin
            disturb = 1'b1;
         end

         // one clock of slack absorbs the sampling jitter of an asynchronous pin
         // period change is a disturbance
         if (ref_rise) begin
            new_period = CNT_MAX;
            if (st.ref_cnt != CNT_MAX) begin
               new_period = st.ref_cnt + CNT_ONE;
            end
            next_st.period = new_period;
            next_st.ref_cnt = CNT_ZERO;
            diff = (new_period > st.period) ? new_period - st.period : st.period - new_period;
            if (diff > CNT_ONE) begin
               disturb = 1'b1;
            end
         end

         // the generator wraps by itself, so outputs keep running if an edge is missed
         // restart the generator on each reference edge, early by adv
         if (ref_rise && !bypass) begin
            gen_nx = (st.adv < new_period) ? st.adv : CNT_ZERO;
         end else if (st.gen_cnt + CNT_ONE >= st.period) begin
            gen_nx = CNT_ZERO;
         end else begin
            gen_nx = st.gen_cnt + CNT_ONE;
         end
         next_st.gen_cnt = gen_nx;
         // loop delay is counted from the generator rise
         if (gen_nx == CNT_ZERO) begin
            next_st.fb_cnt = CNT_ZERO;
         end else if (st.fb_cnt != CNT_MAX) begin
            next_st.fb_cnt = st.fb_cnt + CNT_ONE;
         end

         // one step a period keeps the loop free of overshoot, at the cost of a long pull-in
         // step the advance toward the measured loop delay
         if (fb_rise && !bypass) begin
            if (st.fb_cnt > st.adv) begin
               next_st.adv = st.adv + CNT_ONE;
            end else if (st.fb_cnt < st.adv) begin
               next_st.adv = st.adv - CNT_ONE;
            end
            diff = (st.fb_cnt > st.adv) ? st.fb_cnt - st.adv : st.adv - st.fb_cnt;
            if (diff > CNT_ONE) begin
               disturb = 1'b1;
            end
         end

         // high for half the measured period
         src = (gen_nx < (st.period >> 1)) && (st.period != CNT_ZERO);
         // bypass buffers the sampled reference straight out
         if (bypass) begin
            src = ref_s;
         end
         next_st.src_d = src;

         // enables are taken only while the output is low, so no runt pulses
         if (!st.src_d) begin
            next_st.a_on = synced[SY_EN_A];
            next_st.b_on = synced[SY_EN_B];
         end

         // bank a gated low when disabled
         next_st.bank_a = {BANK_A_N{src & next_st.a_on}};

         // bank b gated low when disabled
         next_st.bank_b = {BANK_B_N{src & next_st.b_on}};

         next_st.fb_o = src;

         // bypass holds lock low, since the loop is not in the path then
         // any disturbance restarts the lock process
         if (disturb || bypass) begin
            next_st.stable = CNT_ZERO;
            next_st.stab_timer = STAB_ZERO;
            next_st.locked = 1'b0;
         end else begin
            if (ref_rise && st.stable != CNT_MAX) begin
               next_st.stable = st.stable + CNT_ONE;
            end
            if (st.stab_timer != STAB_MAX) begin
               next_st.stab_timer = st.stab_timer + 17'h00001;
            end
            // lock after enough stable reference periods
            if (st.stable >= LOCK_REF_CYCLES) begin
               next_st.locked = 1'b1;
            end
            // timer fallback covers references too slow to count enough periods in time
            // never wait past the stabilisation limit while a reference runs
            if (32'(st.stab_timer) >= STAB_CYCLES && st.period != CNT_ZERO) begin
               next_st.locked = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // nine registered copies in two banks
   assign bank_a_outputs = st.bank_a;
   assign bank_b_outputs = st.bank_b;
   assign feedback_out = st.fb_o;
   assign lock_out = st.locked;
endmodule : clock_fanout

// [tb/clock_fanout_props.sv]
// port assertions for the clock fan-out block
// assumes ce_in high while the pins are watched
module clock_fanout_props
   import clock_fanout_pkg::*;
#(
   parameter int unsigned STAB_CYCLES = 2000
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic ref_clock_in,
   input wire logic feedback_in,
   input wire logic bank_a_enable,
   input wire logic bank_b_enable,
   input wire logic analog_supply_strap,
   input wire logic [BANK_A_N-1:0] bank_a_outputs,
   input wire logic [BANK_B_N-1:0] bank_b_outputs,
   input wire logic feedback_out,
   input wire logic lock_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   a_bank_a_same: assert property (bank_a_outputs inside {'0, '1})
      else $error("bank a copies differ");
   a_bank_b_same: assert property (bank_b_outputs inside {'0, '1})
      else $error("bank b copies differ");
   a_bank_a_src: assert property (bank_a_outputs[0] |-> feedback_out)
      else $error("bank a high outside source high");
   a_bank_b_src: assert property (bank_b_outputs[0] |-> feedback_out)
      else $error("bank b high outside source high");
   a_bypass_nolock: assert property (!analog_supply_strap [*4] |-> !lock_out)
      else $error("lock shown in bypass");
   a_bypass_follow: assert property ((ce_in && !analog_supply_strap) [*6]
      |-> feedback_out == $past(ref_clock_in, 3)) else $error("bypass not buffered");
   a_lock_mode: assert property ($rose(lock_out) |-> $past(analog_supply_strap, 3))
      else $error("lock rose in bypass");
   a_lock_settle: assert property ($fell(rst_in) |-> !lock_out [*8])
      else $error("lock without settling");
   a_bank_a_start: assert property ($rose(bank_a_outputs[0]) |-> $rose(feedback_out))
      else $error("bank a started mid phase");
   a_bank_a_end: assert property ($fell(bank_a_outputs[0]) |-> $fell(feedback_out))
      else $error("bank a ended mid phase");
   a_bank_b_start: assert property ($rose(bank_b_outputs[0]) |-> $rose(feedback_out))
      else $error("bank b started mid phase");
   a_bank_b_end: assert property ($fell(bank_b_outputs[0]) |-> $fell(feedback_out))
      else $error("bank b ended mid phase");
endmodule : clock_fanout_props
bind clock_fanout clock_fanout_props #(
   .STAB_CYCLES(STAB_CYCLES)
) u_props (
   .clock_in(clock_in),
   .rst_in(rst_in),
   .ce_in(ce_in),
   .ref_clock_in(ref_clock_in),
   .feedback_in(feedback_in),
   .bank_a_enable(bank_a_enable),
   .bank_b_enable(bank_b_enable),
   .analog_supply_strap(analog_supply_strap),
   .bank_a_outputs(bank_a_outputs),
   .bank_b_outputs(bank_b_outputs),
   .feedback_out(feedback_out),
   .lock_out(lock_out)
);

// [tb/ref_board_model.sv]
// reference source and board feedback trace
// assumes times in ns; low and high lengths differ on purpose
module ref_board_model #(
   parameter int LO_NS = 96,
   parameter int HI_NS = 32,
   parameter int TRACE_NS = 3
) (
   input wire logic ref_run_in,
   input wire logic feedback_out,
   output logic ref_clock_in,
   output logic feedback_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial ref_clock_in = 1'b0;
   always begin
      #LO_NS ref_clock_in = ref_run_in;
      #HI_NS ref_clock_in = 1'b0;
   end
   assign #TRACE_NS feedback_in = feedback_out;
endmodule : ref_board_model

// [tb/pll_clock_fanout_banks_bench.sv]
// self-checking bench for the clock fan-out block
// assumes a 16 clock reference at 25 percent duty from the board model
module pll_clock_fanout_banks_bench
   import clock_fanout_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_in, rst_in, ce_in, ref_run_in, bank_a_enable, bank_b_enable;
   logic analog_supply_strap, ref_clock_in, feedback_in, feedback_out, lock_out;
   logic [BANK_A_N-1:0] bank_a_outputs;
   logic [BANK_B_N-1:0] bank_b_outputs;
   logic [7:0] hi, lo;
   int bad_count, tests_run, cyc;
   time t_ref;
   clock_fanout #(
      .STAB_CYCLES(2000)
   ) u_dut (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .ref_clock_in(ref_clock_in),
      .feedback_in(feedback_in),
      .bank_a_enable(bank_a_enable),
      .bank_b_enable(bank_b_enable),
      .analog_supply_strap(analog_supply_strap),
      .bank_a_outputs(bank_a_outputs),
      .bank_b_outputs(bank_b_outputs),
      .feedback_out(feedback_out),
      .lock_out(lock_out)
   );
   ref_board_model u_model (
      .ref_run_in(ref_run_in),
      .feedback_out(feedback_out),
      .ref_clock_in(ref_clock_in),
      .feedback_in(feedback_in)
   );
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   always @(posedge ref_clock_in) t_ref = $time;
   // run ceiling well above the expected 2000 clocks
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : check
   task automatic meas(output logic [7:0] h, output logic [7:0] l);
      h = 8'h00;
      l = 8'h00;
      while (feedback_out && l < 8'h28) begin @(negedge clock_in); l++; end
      l = 8'h00;
      while (!feedback_out && l < 8'h28) begin @(negedge clock_in); l++; end
      l = 8'h00;
      while (feedback_out && h < 8'h28) begin @(negedge clock_in); h++; end
      while (!feedback_out && l < 8'h28) begin @(negedge clock_in); l++; end
   endtask : meas
   task automatic t_lock;
      @(posedge clock_in);
      ref_run_in <= 1'b1;
      for (int i = 0; i < 2200 && lock_out !== 1'b1; i++) @(negedge clock_in);
      check(lock_out, 8'h01);
      repeat (320) @(negedge clock_in);
      meas(hi, lo);
      check(hi, 8'h08);
      check(hi + lo, 8'h10);
      @(posedge feedback_in);
      check(8'((($time - t_ref + 16) % 128) <= 40), 8'h01);
      $display("lock and alignment test done");
   endtask : t_lock
   task automatic t_bank(input logic on_a);
      logic seen_a, seen_b;
      seen_a = 1'b0;
      seen_b = 1'b0;
      @(posedge clock_in);
      bank_a_enable <= on_a;
      bank_b_enable <= !on_a;
      repeat (40) @(negedge clock_in);
      repeat (32) begin
         @(negedge clock_in);
         seen_a |= |bank_a_outputs;
         seen_b |= |bank_b_outputs;
      end
      check(seen_a, on_a);
      check(seen_b, !on_a);
      $display("bank gating test done");
   endtask : t_bank
   task automatic t_bypass;
      @(posedge clock_in);
      analog_supply_strap <= 1'b0;
      repeat (40) @(negedge clock_in);
      check(lock_out, 8'h00);
      meas(hi, lo);
      check(hi, 8'h04);
      check(lo, 8'h0C);
      $display("bypass test done");
   endtask : t_bypass
   // clock enable low must freeze every output, and running again must resume the copy
   task automatic t_freeze;
      logic [10:0] held;
      logic moved;
      moved = 1'b0;
      @(posedge clock_in);
      ce_in <= 1'b0;
      @(negedge clock_in);
      held = {feedback_out, lock_out, bank_a_outputs, bank_b_outputs};
      repeat (40) begin
         @(negedge clock_in);
         if ({feedback_out, lock_out, bank_a_outputs, bank_b_outputs} != held) begin
            moved = 1'b1;
         end
      end
      check(moved, 8'h00);
      @(posedge clock_in);
      ce_in <= 1'b1;
      repeat (40) @(negedge clock_in);
      meas(hi, lo);
      check(hi, 8'h04);
      $display("clock enable freeze test done");
   endtask : t_freeze
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      ref_run_in = 1'b0;
      bank_a_enable = 1'b1;
      bank_b_enable = 1'b1;
      analog_supply_strap = 1'b1;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      t_lock();
      t_bank(1'b0);
      t_bank(1'b1);
      t_bypass();
      t_freeze();
      final_report();
   end
endmodule : pll_clock_fanout_banks_bench
